/* shared/smc_map.svh */
// constants for the socket mode configuration registers
// assumes a 32-bit word-aligned register bus; printed offsets are register indices
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

`define SMC_IDX_W           15
`define SMC_SOCK_MODE_IDX   15'h0000
`define SMC_RETRY_LIMIT_IDX 15'h420C
`define SMC_HOP_LIMIT_IDX   15'h420F
`define SMC_IRQ_STATUS_IDX  15'h4210
`define SMC_IRQ_MASK_IDX    15'h4211
`define SMC_RETRY_COUNT_IDX 15'h4212
`define SMC_REFUSE_INFO_IDX 15'h4213

`define SMC_MODE_RESET        8'h00
`define SMC_RETRY_LIMIT_RESET 8'h00
`define SMC_HOP_LIMIT_RESET   8'h80
`define SMC_IRQ_RESET         2'h0

`define SMC_OPT7 7
`define SMC_OPT6 6
`define SMC_OPT5 5
`define SMC_OPT4 4

`define SMC_IRQ_W       2
`define SMC_IRQ_TIMEOUT 0
`define SMC_IRQ_REFUSED 1

`define SMC_P_CLOSED    4'h0
`define SMC_P_TCP_V4    4'h1
`define SMC_P_UDP_V4    4'h2
`define SMC_P_RAW_IP_V4 4'h3
`define SMC_P_RAW_ETH   4'h7
`define SMC_P_TCP_V6    4'h9
`define SMC_P_UDP_V6    4'hA
`define SMC_P_RAW_IP_V6 4'hB
`define SMC_P_TCP_DUAL  4'hD
`define SMC_P_UDP_DUAL  4'hE

`define SMC_RESP_OKAY   2'h0
`define SMC_RESP_SLVERR 2'h2

`endif

/* shared/smc_pkg.sv */
// types shared by the socket mode configuration block
// assumes smc_map.svh is on the include path
package smc_pkg;
`include "smc_map.svh"

	typedef enum logic [3:0] {
		PROTO_CLOSED    = `SMC_P_CLOSED,
		PROTO_TCP_V4    = `SMC_P_TCP_V4,
		PROTO_UDP_V4    = `SMC_P_UDP_V4,
		PROTO_RAW_IP_V4 = `SMC_P_RAW_IP_V4,
		PROTO_RAW_ETH   = `SMC_P_RAW_ETH,
		PROTO_TCP_V6    = `SMC_P_TCP_V6,
		PROTO_UDP_V6    = `SMC_P_UDP_V6,
		PROTO_RAW_IP_V6 = `SMC_P_RAW_IP_V6,
		PROTO_TCP_DUAL  = `SMC_P_TCP_DUAL,
		PROTO_UDP_DUAL  = `SMC_P_UDP_DUAL
	} smc_proto_t;

	typedef struct packed {
		logic [3:0] proto;
		logic       modeValid;
		logic       isTcp;
		logic       isUdp;
		logic       isRawEth;
		logic       multicastEnable;
		logic       macAddressFilter;
		logic       broadcastBlock;
		logic       forcePush;
		logic       noDelayedAck;
		logic       igmpVersionSelect;
		logic       solicitedGroupBlock;
		logic       rawV4GroupBlock;
		logic       rawV6GroupBlock;
		logic       unicastBlock;
	} smc_sock_cfg_t;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b01,
		BUS_ANSWER = 2'b10
	} smc_bus_state_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} smc_answer_t;

endpackage

/* core/smc_mode_decode.sv */
// decodes one socket mode byte into protocol class and option flags
// assumes a stored mode byte; purely combinational
`timescale 1ns/1ps
`include "smc_map.svh"
module smc_mode_decode
	import smc_pkg::*;
(
	// mode byte
	input  wire logic [7:0]    modeByte,
	// decoded view
	output smc_sock_cfg_t      cfg
);

	logic [3:0] p;
	logic       b7;
	logic       b6;
	logic       b5;
	logic       b4;
	logic       udpV6Kind;

	always_comb begin
		p = modeByte[3:0];
		b7 = modeByte[`SMC_OPT7];
		b6 = modeByte[`SMC_OPT6];
		b5 = modeByte[`SMC_OPT5];
		b4 = modeByte[`SMC_OPT4];
		cfg = '0;
		cfg.proto = p;
		cfg.isTcp = (p == PROTO_TCP_V4) || (p == PROTO_TCP_V6) || (p == PROTO_TCP_DUAL);
		cfg.isUdp = (p == PROTO_UDP_V4) || (p == PROTO_UDP_V6) || (p == PROTO_UDP_DUAL);
		cfg.isRawEth = (p == PROTO_RAW_ETH);
		cfg.modeValid = cfg.isTcp || cfg.isUdp || cfg.isRawEth || (p == PROTO_CLOSED)
			|| (p == PROTO_RAW_IP_V4) || (p == PROTO_RAW_IP_V6);
		udpV6Kind = (p == PROTO_UDP_V6) || (p == PROTO_UDP_DUAL);
		cfg.multicastEnable = cfg.isUdp && b7;
		cfg.macAddressFilter = cfg.isRawEth && b7;
		cfg.broadcastBlock = (cfg.isUdp || cfg.isRawEth) && b6;
		cfg.forcePush = cfg.isTcp && b6;
		cfg.noDelayedAck = cfg.isTcp && b5;
		cfg.igmpVersionSelect = (p == PROTO_UDP_V4) && b7 && b5;
		cfg.solicitedGroupBlock = udpV6Kind && b5;
		cfg.rawV4GroupBlock = cfg.isRawEth && b7 && b5;
		cfg.unicastBlock = cfg.isUdp && b4;
		cfg.rawV6GroupBlock = cfg.isRawEth && b7 && b4;
	end

endmodule // smc_mode_decode

/* core/smc_config_regs.sv */
// socket mode and socket-less configuration registers behind an Avalon-MM slave
// assumes a single clock, inputs synchronous to clk, and a socket-less engine that pulses start and retry
//
// Notes on behaviour
// - when a socket-less command retries more times than the retry limit, the timeout flag is set.
// - the hop limit register feeds neighbour discovery messages and resets to 128.
// - in a UDP mode bit 7 enables multicast reception.
// - in raw Ethernet mode bit 7 enables the MAC filter.
// - in UDP or raw Ethernet mode bit 6 blocks broadcast reception.
// - in TCP modes bit 6 forces PSH in every data segment.
// - in TCP modes bit 5 chooses immediate acknowledgement over delayed acknowledgement.
// - in TCP modes, after a receive command with the window below the segment size an ACK goes out at once.
// - in UDP v4 with multicast bit 5 selects IGMP version 1 over version 2.
// - in UDP v6 or dual mode bit 5 blocks the solicited-node multicast group.
// - in raw Ethernet with the filter on bit 5 blocks IPv4 multicast.
// - in a UDP mode bit 4 blocks unicast reception.
// - in raw Ethernet with the filter on bit 4 blocks IPv6 multicast.
// - bits 3 to 0 hold the protocol mode code.
// - raw Ethernet mode is accepted only on socket zero.
`timescale 1ns/1ps
`include "smc_map.svh"
module smc_config_regs
	import smc_pkg::*;
#(
	parameter int NUM_SOCKETS = 8
)(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// avalon-mm slave
	input  wire logic [16:0]            address,
	input  wire logic                   read,
	input  wire logic                   write,
	input  wire logic [31:0]            writedata,
	input  wire logic [3:0]             byteenable,
	output logic      [31:0]            readdata,
	output logic      [1:0]             response,
	output logic                        waitrequest,
	// socket-less engine
	input  wire logic                   slCmdStart,
	input  wire logic                   slRetry,
	output logic                        slTimeout,
	output logic      [7:0]             retryLimit,
	output logic      [7:0]             hopLimit,
	// socket engines
	input  wire logic [NUM_SOCKETS-1:0] sockOpen,
	input  wire logic [NUM_SOCKETS-1:0] recvCmd,
	input  wire logic [NUM_SOCKETS-1:0] windowBelowMss,
	output logic      [NUM_SOCKETS-1:0] ackNow,
	output smc_sock_cfg_t               sockCfg [NUM_SOCKETS],
	// interrupt
	output logic                        irq
);

	localparam int SOCK_W = (NUM_SOCKETS > 1) ? $clog2(NUM_SOCKETS) : 1;

	smc_bus_state_t             busState;
	smc_answer_t                answer;
	logic [`SMC_IDX_W-1:0]      idx;
	logic                       req;
	logic                       sockHit;
	logic                       retryHit;
	logic                       hopHit;
	logic                       statusHit;
	logic                       maskHit;
	logic                       countHit;
	logic                       infoHit;
	logic                       mapped;
	logic [SOCK_W-1:0]          sockSel;
	logic                       wrCommit;
	logic [7:0]                 wrByte;
	logic                       modeLegal;
	logic                       modeRefuse;
	logic [7:0]                 modeReg [NUM_SOCKETS];
	smc_sock_cfg_t              decoded [NUM_SOCKETS];
	logic [`SMC_IRQ_W-1:0]      irqStatus;
	logic [`SMC_IRQ_W-1:0]      irqMask;
	logic [`SMC_IRQ_W-1:0]      irqSet;
	logic [`SMC_IRQ_W-1:0]      irqClr;
	logic [`SMC_IRQ_W-1:0]      next_irqStatus;
	logic [8:0]                 retryCount;
	logic [8:0]                 next_retryCount;
	logic                       retryArmed;
	logic                       timeoutEvt;
	logic [7:0]                 refuseInfo;
	logic [7:0]                 rdByte;

	assign req = read || write;
	assign idx = address[16:2];
	assign wrByte = writedata[7:0];

	// address decode; low two address bits are ignored, registers are word aligned
	always_comb begin
		sockHit = 1'b0;
		retryHit = 1'b0;
		hopHit = 1'b0;
		statusHit = 1'b0;
		maskHit = 1'b0;
		countHit = 1'b0;
		infoHit = 1'b0;
		sockSel = idx[SOCK_W-1:0];
		if (idx < (`SMC_SOCK_MODE_IDX + `SMC_IDX_W'(NUM_SOCKETS))) begin
			sockHit = 1'b1;
		end else if (idx == `SMC_RETRY_LIMIT_IDX) begin
			retryHit = 1'b1;
		end else if (idx == `SMC_HOP_LIMIT_IDX) begin
			hopHit = 1'b1;
		end else if (idx == `SMC_IRQ_STATUS_IDX) begin
			statusHit = 1'b1;
		end else if (idx == `SMC_IRQ_MASK_IDX) begin
			maskHit = 1'b1;
		end else if (idx == `SMC_RETRY_COUNT_IDX) begin
			countHit = 1'b1;
		end else if (idx == `SMC_REFUSE_INFO_IDX) begin
			infoHit = 1'b1;
		end
		mapped = sockHit || retryHit || hopHit || statusHit || maskHit || countHit || infoHit;
	end

	// legality of a mode byte for the addressed socket
	always_comb begin
		case (wrByte[3:0])
			`SMC_P_CLOSED,
			`SMC_P_TCP_V4,
			`SMC_P_UDP_V4,
			`SMC_P_RAW_IP_V4,
			`SMC_P_TCP_V6,
			`SMC_P_UDP_V6,
			`SMC_P_RAW_IP_V6,
			`SMC_P_TCP_DUAL,
			`SMC_P_UDP_DUAL: begin
				modeLegal = 1'b1;
			end
			`SMC_P_RAW_ETH: begin
				modeLegal = (sockSel == '0);
			end
			default: begin
				modeLegal = 1'b0;
			end
		endcase
	end

	// an open socket keeps its mode; protocol engines latch it only at open
	assign modeRefuse = sockHit && byteenable[0] && (!modeLegal || sockOpen[sockSel]);

	// the write lands at the edge where the master sees waitrequest low
	assign wrCommit = (busState == BUS_ANSWER) && write && byteenable[0];

	// read mux
	always_comb begin
		rdByte = 8'h00;
		if (sockHit) begin
			rdByte = modeReg[sockSel];
		end else if (retryHit) begin
			rdByte = retryLimit;
		end else if (hopHit) begin
			rdByte = hopLimit;
		end else if (statusHit) begin
			rdByte = {{(8-`SMC_IRQ_W){1'b0}}, irqStatus};
		end else if (maskHit) begin
			rdByte = {{(8-`SMC_IRQ_W){1'b0}}, irqMask};
		end else if (countHit) begin
			rdByte = retryCount[8] ? 8'hFF : retryCount[7:0];
		end else if (infoHit) begin
			rdByte = refuseInfo;
		end
	end

	// answer built in the idle cycle so that data and response stand when waitrequest falls
	always_comb begin
		answer.data = {24'h000000, rdByte};
		answer.resp = `SMC_RESP_OKAY;
		if (!mapped) begin
			answer.data = 32'h00000000;
			answer.resp = `SMC_RESP_SLVERR;
		end else if (write && modeRefuse) begin
			answer.resp = `SMC_RESP_SLVERR;
		end
	end

	// bus handshake: one idle cycle, one answer cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busState <= BUS_IDLE;
		end else begin
			case (busState)
				BUS_IDLE: begin
					if (req) begin
						busState <= BUS_ANSWER;
					end
				end
				BUS_ANSWER: begin
					busState <= BUS_IDLE;
				end
				default: begin
					busState <= BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
			response <= `SMC_RESP_OKAY;
		end else begin
			waitrequest <= !((busState == BUS_IDLE) && req);
			if ((busState == BUS_IDLE) && req) begin
				readdata <= read ? answer.data : 32'h00000000;
				response <= answer.resp;
			end
		end
	end

	// socket mode registers and their decoded, registered view
	genvar g;
	generate
		for (g = 0; g < NUM_SOCKETS; g = g + 1) begin : gSock
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					modeReg[g] <= `SMC_MODE_RESET;
				end else if (wrCommit && sockHit && (sockSel == SOCK_W'(g)) && !modeRefuse) begin
					modeReg[g] <= wrByte;
				end
			end

			smc_mode_decode uDecode (
				.modeByte (modeReg[g]),
				.cfg      (decoded[g])
			);

			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					sockCfg[g] <= '0;
				end else begin
					sockCfg[g] <= decoded[g];
				end
			end

			// window below segment size overrides the delayed acknowledgement choice
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					ackNow[g] <= 1'b0;
				end else begin
					ackNow[g] <= recvCmd[g] && windowBelowMss[g] && decoded[g].isTcp;
				end
			end
		end
	endgenerate

	// socket-less limits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			retryLimit <= `SMC_RETRY_LIMIT_RESET;
		end else if (wrCommit && retryHit) begin
			retryLimit <= wrByte;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hopLimit <= `SMC_HOP_LIMIT_RESET;
		end else if (wrCommit && hopHit) begin
			hopLimit <= wrByte;
		end
	end

	// retry counting; nine bits so a limit of 255 can still be exceeded
	always_comb begin
		next_retryCount = retryCount;
		timeoutEvt = 1'b0;
		if (slCmdStart) begin
			next_retryCount = 9'h000;
		end else if (slRetry && retryArmed) begin
			next_retryCount = retryCount + 9'h001;
			timeoutEvt = (next_retryCount > {1'b0, retryLimit});
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			retryCount <= 9'h000;
			retryArmed <= 1'b0;
			slTimeout <= 1'b0;
		end else begin
			retryCount <= next_retryCount;
			slTimeout <= timeoutEvt;
			if (slCmdStart) begin
				retryArmed <= 1'b1;
			end else if (timeoutEvt) begin
				retryArmed <= 1'b0; // one timeout per command
			end
		end
	end

	// last refused mode write: bit 7 set, bit 6 open socket, low bits socket number
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			refuseInfo <= 8'h00;
		end else if (wrCommit && modeRefuse) begin
			refuseInfo <= {1'b1, sockOpen[sockSel], 6'(sockSel)};
		end
	end

	// sticky events; a set in the clearing cycle survives
	always_comb begin
		irqSet = '0;
		irqSet[`SMC_IRQ_TIMEOUT] = timeoutEvt;
		irqSet[`SMC_IRQ_REFUSED] = wrCommit && modeRefuse;
		irqClr = (wrCommit && statusHit) ? wrByte[`SMC_IRQ_W-1:0] : '0;
		next_irqStatus = (irqStatus & ~irqClr) | irqSet;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqStatus <= `SMC_IRQ_RESET;
		end else begin
			irqStatus <= next_irqStatus;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqMask <= `SMC_IRQ_RESET;
		end else if (wrCommit && maskHit) begin
			irqMask <= wrByte[`SMC_IRQ_W-1:0];
		end
	end

	// irq lags status by one cycle so that it comes from a flip-flop
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
		end
	end

endmodule // smc_config_regs

/* bench/smc_host_model.sv */
// host model: avalon-mm master that reaches the configuration registers
// assumes a slave that lowers waitrequest for one cycle per request
`timescale 1ns/1ps
module smc_host_model (
	// clock
	input  wire logic        clk,
	// avalon-mm master
	output logic      [16:0] address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	output logic      [3:0]  byteenable,
	input  wire logic        waitrequest
);
	bit hung;
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'hF;
	end
	// held until an edge sees waitrequest low; unused address and data bits random
	task automatic access(input bit wr, input logic [14:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		address <= {idx, 2'($urandom())};
		read <= !wr;
		write <= wr;
		writedata <= {24'($urandom()), d};
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 64);
		hung = waitrequest !== 1'b0;
		read <= 1'b0;
		write <= 1'b0;
		// one idle edge: the next request never rises in the step of this release
		@(posedge clk);
	endtask
endmodule // smc_host_model

/* bench/smc_config_props.sv */
// assertions on the configuration register block
// assumes it is bound to smc_config_regs
`timescale 1ns/1ps
module smc_config_props
	import smc_pkg::*;
#(
	parameter int NUM_SOCKETS = 8
)(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// bus
	input  wire logic [16:0]            address,
	input  wire logic                   read,
	input  wire logic                   waitrequest,
	input  wire logic [31:0]            readdata,
	input  wire logic [1:0]             response,
	// engines
	input  wire logic                   slRetry,
	input  wire logic                   slTimeout,
	input  wire logic [7:0]             retryLimit,
	input  wire logic [7:0]             hopLimit,
	input  wire logic [NUM_SOCKETS-1:0] recvCmd,
	input  wire logic [NUM_SOCKETS-1:0] windowBelowMss,
	input  wire logic [NUM_SOCKETS-1:0] ackNow,
	input  wire smc_sock_cfg_t          sockCfg [NUM_SOCKETS]
);
	logic rawElse;
	always_comb begin
		rawElse = 1'b0;
		for (int k = 1; k < NUM_SOCKETS; k++) rawElse |= sockCfg[k].proto == 4'h7;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	hop_read_a: assert property (read && waitrequest && address[16:2] == 15'h420F |=> readdata[7:0] == hopLimit)
		else $error("hop limit readback differs");
	limit_read_a: assert property (read && waitrequest && address[16:2] == 15'h420C |=> readdata[7:0] == retryLimit)
		else $error("retry limit readback differs");
	timeout_pulse_a: assert property (slTimeout |=> !slTimeout)
		else $error("timeout flag longer than one cycle");
	timeout_cause_a: assert property (slTimeout |-> $past(slRetry))
		else $error("timeout without a retry");
	ack_cause_a: assert property (|ackNow |-> (ackNow & ~$past(recvCmd & windowBelowMss)) == '0)
		else $error("ack without receive and small window");
	raw_sock0_a: assert property (!rawElse)
		else $error("raw ethernet mode on a socket other than zero");
	tcp_opts_a: assert property (sockCfg[0].forcePush || sockCfg[0].noDelayedAck |-> sockCfg[0].isTcp)
		else $error("tcp option outside tcp mode");
	udp_opts_a: assert property (sockCfg[0].multicastEnable || sockCfg[0].unicastBlock |-> sockCfg[0].isUdp)
		else $error("udp option outside udp mode");
	raw_filter_a: assert property (sockCfg[0].rawV4GroupBlock || sockCfg[0].rawV6GroupBlock |-> sockCfg[0].macAddressFilter)
		else $error("group block without mac filter");
	cover property (slTimeout);
	cover property (|ackNow);
	cover property (!waitrequest && response == 2'h2);
endmodule // smc_config_props

bind smc_config_regs smc_config_props #(.NUM_SOCKETS(NUM_SOCKETS)) props (.*);

/* bench/testbench.sv */
// self-checking bench for the socket mode configuration registers
// assumes the host model drives the bus and the bound checker watches the ports
`timescale 1ns/1ps
module testbench;
	import smc_pkg::*;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED t=%0t got %h want %h", $time, g, e); end end
	typedef struct {bit rd; logic [7:0] d; logic [1:0] r;} smc_exp_t;
	logic          clk = 0, arst_n = 0, read, write, waitrequest, slCmdStart = 0, slRetry = 0, slTimeout, irq, ok;
	logic [16:0]   address;
	logic [31:0]   writedata, readdata;
	logic [3:0]    byteenable;
	logic [1:0]    response;
	logic [7:0]    retryLimit, hopLimit, m, sockOpen = 0, recvCmd = 0, windowBelowMss = 0, ackNow;
	logic [7:0]    last [8];
	int            s, fails, n_compared;
	smc_sock_cfg_t e, g, sockCfg [8];
	smc_exp_t      expQ [$], x;
	always #50 clk = ~clk;
	smc_config_regs dut (.*);
	smc_host_model host (.*);
	// option flags are only meaningful in their own modes
	function automatic smc_sock_cfg_t expCfg(logic [7:0] v);
		logic u, t, r;
		expCfg = '0;
		u = v[3:0] inside {4'h2, 4'hA, 4'hE};
		t = v[3:0] inside {4'h1, 4'h9, 4'hD};
		r = v[3:0] == 4'h7;
		expCfg.proto = v[3:0];
		expCfg.modeValid = v[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE};
		expCfg.isTcp = t;
		expCfg.isUdp = u;
		expCfg.isRawEth = r;
		expCfg.multicastEnable = u & v[7];
		expCfg.macAddressFilter = r & v[7];
		expCfg.broadcastBlock = (u | r) & v[6];
		expCfg.forcePush = t & v[6];
		expCfg.noDelayedAck = t & v[5];
		expCfg.igmpVersionSelect = (v[3:0] == 4'h2) & v[7] & v[5];
		expCfg.solicitedGroupBlock = (v[3:0] inside {4'hA, 4'hE}) & v[5];
		expCfg.rawV4GroupBlock = r & v[7] & v[5];
		expCfg.rawV6GroupBlock = r & v[7] & v[4];
		expCfg.unicastBlock = u & v[4];
	endfunction
	task automatic close_out;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic acc(input bit wr, input logic [14:0] idx, input logic [7:0] d, input logic [7:0] ed,
		input logic [1:0] er);
		expQ.push_back('{!wr, ed, er});
		host.access(wr, idx, d);
		if (host.hung) begin
			fails++;
			close_out();
		end
	endtask
	always @(posedge clk) begin
		if ((read || write) && waitrequest === 1'b0) begin
			if (expQ.size() == 0) begin
				fails++;
				$display("CHECK FAILED t=%0t unexpected answer", $time);
			end else begin
				x = expQ.pop_front();
				if (x.rd) `CHK(readdata, {24'h0, x.d})
				`CHK(response, x.r)
			end
		end
	end
	initial begin
		repeat (50000) @(posedge clk);
		fails++;
		close_out();
	end
	initial begin
		void'($urandom(32'hC99D));
		last = '{default: 8'h00};
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		acc(0, 15'h420C, 0, 8'h00, 2'h0);
		acc(0, 15'h420F, 0, 8'h80, 2'h0);
		acc(0, 15'h4214, 0, 8'h00, 2'h2);
		`CHK(hopLimit, 8'h80)
		// every mode byte once, on a random socket
		for (int k = 0; k < 256; k++) begin
			m = 8'(k);
			s = $urandom_range(7, 0);
			ok = m[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE} || (m[3:0] == 4'h7 && s == 0);
			acc(1, 15'(s), m, 0, ok ? 2'h0 : 2'h2);
			if (ok) last[s] = m;
			acc(0, 15'(s), 0, last[s], 2'h0);
			e = expCfg(last[s]);
			g = sockCfg[s];
			`CHK(g, e)
		end
		`CHK(irq, 1'b0)
		sockOpen <= 8'h04;
		acc(1, 15'h0002, 8'h02, 0, 2'h2);
		acc(0, 15'h0002, 0, last[2], 2'h0);
		acc(0, 15'h4213, 0, 8'hC2, 2'h0);
		acc(0, 15'h4210, 0, 8'h02, 2'h0);
		acc(1, 15'h4210, 8'h02, 0, 2'h0);
		acc(0, 15'h4210, 0, 8'h00, 2'h0);
		acc(1, 15'h420F, 8'h40, 0, 2'h0);
		acc(0, 15'h420F, 0, 8'h40, 2'h0);
		acc(1, 15'h420C, 8'h02, 0, 2'h0);
		acc(1, 15'h4211, 8'h01, 0, 2'h0);
		`CHK(retryLimit, 8'h02)
		slCmdStart <= 1'b1;
		@(posedge clk);
		slCmdStart <= 1'b0;
		for (int i = 1; i <= 3; i++) begin
			slRetry <= 1'b1;
			@(posedge clk);
			slRetry <= 1'b0;
			@(posedge clk);
			`CHK(slTimeout, i == 3)
		end
		@(posedge clk);
		`CHK(irq, 1'b1)
		acc(0, 15'h4212, 0, 8'h03, 2'h0);
		acc(1, 15'h4210, 8'h01, 0, 2'h0);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		acc(1, 15'h0003, 8'h01, 0, 2'h0);
		acc(1, 15'h0004, 8'h02, 0, 2'h0);
		recvCmd <= 8'h38;
		windowBelowMss <= 8'h18;
		@(posedge clk);
		recvCmd <= 8'h00;
		@(posedge clk);
		`CHK(ackNow, 8'h08)
		close_out();
	end
endmodule // testbench
